// ### hw/dfs_chan_flags.sv
// One channel's four sticky event flags with their clear controls.
`timescale 1ns/1ps

module dfs_chan_flags
(
  // Clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       rst_i,
  input  wire logic       ce_i,
  // Event strobes
  input  wire logic       done_event_i,
  input  wire logic       halfway_event_i,
  input  wire logic       fault_event_i,
  // Clear nibble, valid only while clear_we_i is high
  input  wire logic       clear_we_i,
  input  wire logic [3:0] clear_i,
  // Flag nibble
  output logic      [3:0] flags_o
);

  typedef struct packed {
    logic done;
    logic half;
    logic fault;
    logic any;
  } dfs_chan_s;

  dfs_chan_s st;
  dfs_chan_s next_st;
  logic      clr_any;
  logic      clr_done;
  logic      clr_half;
  logic      clr_fault;

  // ==========================================================================
  // Next state: a set in the same cycle as a clear wins so no event is lost.
  always_comb
  begin
    next_st   = st;
    clr_any   = clear_we_i & clear_i[dfs_pkg::POS_ANY];
    clr_done  = clear_we_i & (clear_i[dfs_pkg::POS_DONE] | clr_any);
    clr_half  = clear_we_i & (clear_i[dfs_pkg::POS_HALF] | clr_any);
    clr_fault = clear_we_i & (clear_i[dfs_pkg::POS_FAULT] | clr_any);
    if (clr_done)
    begin
      next_st.done = 1'b0;
    end
    if (clr_half)
    begin
      next_st.half = 1'b0;
    end
    if (clr_fault)
    begin
      next_st.fault = 1'b0;
    end
    if (clr_any)
    begin
      next_st.any = 1'b0;
    end
    if (done_event_i)
    begin
      next_st.done = 1'b1;
    end
    if (halfway_event_i)
    begin
      next_st.half = 1'b1;
    end
    if (fault_event_i)
    begin
      next_st.fault = 1'b1;
    end
    if (done_event_i | halfway_event_i | fault_event_i)
    begin
      next_st.any = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st <= '0;
    end
    else if (ce_i)
    begin
      st <= next_st;
    end
  end

  always_comb
  begin
    flags_o                         = '0;
    flags_o[dfs_pkg::POS_ANY]       = st.any;
    flags_o[dfs_pkg::POS_DONE]      = st.done;
    flags_o[dfs_pkg::POS_HALF]      = st.half;
    flags_o[dfs_pkg::POS_FAULT]     = st.fault;
  end

endmodule : dfs_chan_flags

// ### hw/dfs_pkg.sv
// Package of constants for the DMA channel flag status and clear block.
package dfs_pkg;

  // ==========================================================================
  // Geometry
  localparam int unsigned NUM_CH      = 8;
  localparam int unsigned FLD_PER_CH  = 4;
  localparam int unsigned DATA_W      = 32;
  localparam int unsigned ADDR_W      = 12;

  // ==========================================================================
  // Field positions inside a channel nibble, shared by status and clear
  localparam int unsigned POS_ANY     = 0;
  localparam int unsigned POS_DONE    = 1;
  localparam int unsigned POS_HALF    = 2;
  localparam int unsigned POS_FAULT   = 3;

  // ==========================================================================
  // Register byte offsets
  localparam logic [11:0] OFS_STATUS  = 12'h000;
  localparam logic [11:0] OFS_CLEAR   = 12'h004;
  localparam logic [11:0] OFS_IRQ_ST  = 12'h008;
  localparam logic [11:0] OFS_IRQ_MSK = 12'h00C;

  // ==========================================================================
  // Reset values
  localparam logic [31:0] RST_FLAGS   = 32'h0000_0000;
  localparam logic [31:0] RST_MASK    = 32'h0000_0000;
  localparam logic [31:0] RST_RDATA   = 32'h0000_0000;
  localparam logic [31:0] READ_ZERO   = 32'h0000_0000;

  // ==========================================================================
  // Bus slave state
  typedef enum logic [0:0] {
    DFS_IDLE   = 1'b0,
    DFS_ANSWER = 1'b1
  } dfs_bus_e;

endpackage : dfs_pkg

// ### hw/dfs_top.sv
// APB register block holding the eight-channel DMA event flags and their clears.
//
// Summary of operation
// - Channel 7 completion sets status bit 29, held until software clears it.
// - Channel 7 halfway event sets status bit 30, held until cleared.
// - Channel 7 error sets status bit 31, held until a one is written.
// - Channel any-event flag is one after any error, halfway or completion.
// - Clear register sits at offset 0x04, write-only, reset to zero.
// - Writing one to a global clear bit clears all four channel flags.
// - Writing one to a completion clear bit clears only that completion flag.
// - Writing one to a halfway clear bit clears only that halfway flag.
// - Writing one to an error clear bit clears only that error flag.
// - Writing zero to any clear bit leaves every flag unchanged.
// - Clear bits per channel start at four times channel: global, done, half, error.
// - Status flags per channel start at four times channel; all reset to zero.
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps

module dfs_top
(
  // Clock, reset and enable
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  input  wire logic [3:0]  pstrb_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Channel event strobes, one bit per channel
  input  wire logic [7:0]  done_event_i,
  input  wire logic [7:0]  halfway_event_i,
  input  wire logic [7:0]  fault_event_i,
  // Interrupt
  output logic             irq_o
);

  // ==========================================================================
  // State
  typedef struct packed {
    dfs_pkg::dfs_bus_e bus;
    logic              ready;
    logic [31:0]       rdata;
    logic              slverr;
    logic [31:0]       irq_st;
    logic [31:0]       irq_msk;
    logic [31:0]       flags_q;
    logic              irq;
  } dfs_top_s;

  dfs_top_s    st;
  dfs_top_s    next_st;
  logic [31:0] flags;
  logic [31:0] clear_val;
  logic        clear_we;
  logic        setup;
  logic        wr_hit;
  logic [31:0] wmask;
  logic [31:0] new_evt;
  logic        hit_status;
  logic        hit_clear;
  logic        hit_irq_st;
  logic        hit_irq_msk;
  logic [31:0] rd_mux;
  logic        rd_err;
  logic [31:0] irq_clr;
  logic        msk_we;

  // ==========================================================================
  // Byte lane mask from the write strobes.
  always_comb
  begin
    wmask = {{8{pstrb_i[3]}}, {8{pstrb_i[2]}}, {8{pstrb_i[1]}}, {8{pstrb_i[0]}}};
  end

  // The clear strobe fires once, in the setup cycle of a write, so a long access phase cannot clear twice.
  always_comb
  begin
    setup     = psel_i & ~penable_i & (st.bus == dfs_pkg::DFS_IDLE);
    wr_hit    = setup & pwrite_i;
    clear_we  = ce_i & wr_hit & hit_clear;
    clear_val = pwdata_i & wmask;
  end

  // ==========================================================================
  // Address decode, shared by the read path and the write path.
  always_comb
  begin
    hit_status  = (paddr_i == dfs_pkg::OFS_STATUS);
    hit_clear   = (paddr_i == dfs_pkg::OFS_CLEAR);
    hit_irq_st  = (paddr_i == dfs_pkg::OFS_IRQ_ST);
    hit_irq_msk = (paddr_i == dfs_pkg::OFS_IRQ_MSK);
  end

  // ==========================================================================
  // Read data and error response, captured in the setup cycle.
  // An unmapped address reads zero and answers with an error.
  always_comb
  begin
    rd_mux = dfs_pkg::READ_ZERO;
    rd_err = 1'b1;
    if (hit_status)
    begin
      rd_mux = flags;
      rd_err = pwrite_i;
    end
    if (hit_clear)
    begin
      rd_mux = dfs_pkg::READ_ZERO;
      rd_err = ~pwrite_i;
    end
    if (hit_irq_st)
    begin
      rd_mux = st.irq_st;
      rd_err = 1'b0;
    end
    if (hit_irq_msk)
    begin
      rd_mux = st.irq_msk;
      rd_err = 1'b0;
    end
  end

  // ==========================================================================
  // Interrupt register writes take effect in the setup cycle only; a new event still wins.
  // Mask writes honour the byte strobes just as the clear does.
  always_comb
  begin
    irq_clr = '0;
    msk_we  = setup & pwrite_i & hit_irq_msk;
    if (setup & pwrite_i & hit_irq_st)
    begin
      irq_clr = pwdata_i & wmask;
    end
  end

  // ==========================================================================
  // Channel 0 owns clear and status bits 3 to 0.
  // Its events arrive on bit 0 of each event bus.
  dfs_chan_flags u_dfs_chan_flags_0
  (
    .sys_clk_i       (sys_clk_i),
    .rst_i           (rst_i),
    .ce_i            (ce_i),
    .done_event_i    (done_event_i[0]),
    .halfway_event_i (halfway_event_i[0]),
    .fault_event_i   (fault_event_i[0]),
    .clear_we_i      (clear_we),
    .clear_i         (clear_val[3:0]),
    .flags_o         (flags[3:0])
  );

  // ==========================================================================
  // Channel 1 owns clear and status bits 7 to 4.
  // Its events arrive on bit 1 of each event bus.
  dfs_chan_flags u_dfs_chan_flags_1
  (
    .sys_clk_i       (sys_clk_i),
    .rst_i           (rst_i),
    .ce_i            (ce_i),
    .done_event_i    (done_event_i[1]),
    .halfway_event_i (halfway_event_i[1]),
    .fault_event_i   (fault_event_i[1]),
    .clear_we_i      (clear_we),
    .clear_i         (clear_val[7:4]),
    .flags_o         (flags[7:4])
  );

  // ==========================================================================
  // Channel 2 owns clear and status bits 11 to 8.
  // Its events arrive on bit 2 of each event bus.
  dfs_chan_flags u_dfs_chan_flags_2
  (
    .sys_clk_i       (sys_clk_i),
    .rst_i           (rst_i),
    .ce_i            (ce_i),
    .done_event_i    (done_event_i[2]),
    .halfway_event_i (halfway_event_i[2]),
    .fault_event_i   (fault_event_i[2]),
    .clear_we_i      (clear_we),
    .clear_i         (clear_val[11:8]),
    .flags_o         (flags[11:8])
  );

  // ==========================================================================
  // Channel 3 owns clear and status bits 15 to 12.
  // Its events arrive on bit 3 of each event bus.
  dfs_chan_flags u_dfs_chan_flags_3
  (
    .sys_clk_i       (sys_clk_i),
    .rst_i           (rst_i),
    .ce_i            (ce_i),
    .done_event_i    (done_event_i[3]),
    .halfway_event_i (halfway_event_i[3]),
    .fault_event_i   (fault_event_i[3]),
    .clear_we_i      (clear_we),
    .clear_i         (clear_val[15:12]),
    .flags_o         (flags[15:12])
  );

  // ==========================================================================
  // Channel 4 owns clear and status bits 19 to 16.
  // Its events arrive on bit 4 of each event bus.
  dfs_chan_flags u_dfs_chan_flags_4
  (
    .sys_clk_i       (sys_clk_i),
    .rst_i           (rst_i),
    .ce_i            (ce_i),
    .done_event_i    (done_event_i[4]),
    .halfway_event_i (halfway_event_i[4]),
    .fault_event_i   (fault_event_i[4]),
    .clear_we_i      (clear_we),
    .clear_i         (clear_val[19:16]),
    .flags_o         (flags[19:16])
  );

  // ==========================================================================
  // Channel 5 owns clear and status bits 23 to 20.
  // Its events arrive on bit 5 of each event bus.
  dfs_chan_flags u_dfs_chan_flags_5
  (
    .sys_clk_i       (sys_clk_i),
    .rst_i           (rst_i),
    .ce_i            (ce_i),
    .done_event_i    (done_event_i[5]),
    .halfway_event_i (halfway_event_i[5]),
    .fault_event_i   (fault_event_i[5]),
    .clear_we_i      (clear_we),
    .clear_i         (clear_val[23:20]),
    .flags_o         (flags[23:20])
  );

  // ==========================================================================
  // Channel 6 owns clear and status bits 27 to 24.
  // Its events arrive on bit 6 of each event bus.
  dfs_chan_flags u_dfs_chan_flags_6
  (
    .sys_clk_i       (sys_clk_i),
    .rst_i           (rst_i),
    .ce_i            (ce_i),
    .done_event_i    (done_event_i[6]),
    .halfway_event_i (halfway_event_i[6]),
    .fault_event_i   (fault_event_i[6]),
    .clear_we_i      (clear_we),
    .clear_i         (clear_val[27:24]),
    .flags_o         (flags[27:24])
  );

  // ==========================================================================
  // Channel 7 owns clear and status bits 31 to 28.
  // Its events arrive on bit 7 of each event bus.
  dfs_chan_flags u_dfs_chan_flags_7
  (
    .sys_clk_i       (sys_clk_i),
    .rst_i           (rst_i),
    .ce_i            (ce_i),
    .done_event_i    (done_event_i[7]),
    .halfway_event_i (halfway_event_i[7]),
    .fault_event_i   (fault_event_i[7]),
    .clear_we_i      (clear_we),
    .clear_i         (clear_val[31:28]),
    .flags_o         (flags[31:28])
  );

  // ==========================================================================
  // Interrupt events are rising edges of any status flag.
  always_comb
  begin
    new_evt = flags & ~st.flags_q;
  end

  // ==========================================================================
  // Register and bus next state
  always_comb
  begin
    next_st         = st;
    next_st.flags_q = flags;
    next_st.irq_st  = (st.irq_st & ~irq_clr) | new_evt;
    if (msk_we)
    begin
      next_st.irq_msk = (st.irq_msk & ~wmask) | (pwdata_i & wmask);
    end
    case (st.bus)
      dfs_pkg::DFS_IDLE:
      begin
        if (setup)
        begin
          // Data and error are latched here so the answer comes straight from flip-flops.
          next_st.bus    = dfs_pkg::DFS_ANSWER;
          next_st.ready  = 1'b1;
          next_st.rdata  = rd_mux;
          next_st.slverr = rd_err;
        end
      end
      // The answer lasts one cycle; the next setup may follow at once.
      dfs_pkg::DFS_ANSWER:
      begin
        next_st.bus    = dfs_pkg::DFS_IDLE;
        next_st.ready  = 1'b0;
        next_st.slverr = 1'b0;
      end
      default:
      begin
        next_st.bus   = dfs_pkg::DFS_IDLE;
        next_st.ready = 1'b0;
      end
    endcase
    next_st.irq = |(next_st.irq_st & next_st.irq_msk);
  end

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st.bus     <= dfs_pkg::DFS_IDLE;
      st.ready   <= 1'b0;
      st.rdata   <= dfs_pkg::RST_RDATA;
      st.slverr  <= 1'b0;
      st.irq_st  <= dfs_pkg::RST_FLAGS;
      st.irq_msk <= dfs_pkg::RST_MASK;
      st.flags_q <= dfs_pkg::RST_FLAGS;
      st.irq     <= 1'b0;
    end
    else if (ce_i)
    begin
      st <= next_st;
    end
  end

  // ==========================================================================
  // Outputs, all straight from flip-flops
  always_comb
  begin
    prdata_o  = st.rdata;
    pready_o  = st.ready;
    pslverr_o = st.slverr;
    irq_o     = st.irq;
  end

endmodule : dfs_top

// ### tb/dfs_top_sva.sv
// Checker of bus timing and channel 7 flag behaviour at the flag block ports.
`timescale 1ns/1ps
module dfs_top_sva
(
  // Clock and reset
  input wire logic        sys_clk_i,
  input wire logic        rst_i,
  input wire logic        ce_i,
  // Bus
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  // Events
  input wire logic [7:0]  done_event_i,
  input wire logic [7:0]  halfway_event_i,
  input wire logic [7:0]  fault_event_i
);
  // ==========================================================================
  // Properties
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  a_ready_after_setup: assert property (ce_i && psel_i && !penable_i |=> pready_o) else $error("no ready");
  a_ready_one_cycle: assert property (ce_i && pready_o |=> !pready_o) else $error("ready too long");
  a_clear_reads_zero: assert property (ce_i && psel_i && !penable_i && !pwrite_i && paddr_i == 12'h004
    |=> prdata_o == 32'h0000_0000 && pslverr_o) else $error("clear reg readable");
  a_status_write_err: assert property (ce_i && psel_i && !penable_i && pwrite_i && paddr_i == 12'h000
    |=> pslverr_o) else $error("status write accepted");
  a_done_seven_set: assert property (ce_i && done_event_i[7] ##1 ce_i && psel_i && !penable_i && !pwrite_i
    && paddr_i == 12'h000 |=> prdata_o[29] && prdata_o[28]) else $error("done flag missing");
  a_half_seven_set: assert property (ce_i && halfway_event_i[7] ##1 ce_i && psel_i && !penable_i && !pwrite_i
    && paddr_i == 12'h000 |=> prdata_o[30] && prdata_o[28]) else $error("halfway flag missing");
  a_fault_seven_set: assert property (ce_i && fault_event_i[7] ##1 ce_i && psel_i && !penable_i && !pwrite_i
    && paddr_i == 12'h000 |=> prdata_o[31] && prdata_o[28]) else $error("fault flag missing");
  a_done_seven_clr: assert property (ce_i && psel_i && !penable_i && pwrite_i && paddr_i == 12'h004
    && pwdata_i[29] && !done_event_i[7] ##1 !done_event_i[7] ##1 !done_event_i[7]
    ##1 ce_i && psel_i && !penable_i && !pwrite_i && paddr_i == 12'h000 |=> !prdata_o[29])
    else $error("done flag not cleared");
endmodule : dfs_top_sva

bind dfs_top dfs_top_sva u_dfs_top_sva (.sys_clk_i, .rst_i, .ce_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
  .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .done_event_i, .halfway_event_i, .fault_event_i);

// ### tb/dfs_top_tb.sv
// Self-checking bench for the DMA flag status and clear block.
`timescale 1ns/1ps
module dfs_top_tb;
  // ==========================================================================
  // Signals
  logic        sys_clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        ce_i = 1'b1;
  logic        psel_i = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0000_0000;
  logic [3:0]  pstrb_i = 4'hF;
  logic [31:0] prdata_o;
  logic        pready_o;
  logic        pslverr_o;
  logic        irq_o;
  logic [7:0]  done_event_i = 8'h00;
  logic [7:0]  halfway_event_i = 8'h00;
  logic [7:0]  fault_event_i = 8'h00;
  logic [31:0] rd;
  int          n_errors = 0;
  int          n_compared = 0;

  dfs_top u_dfs_top (.sys_clk_i, .rst_i, .ce_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i,
    .prdata_o, .pready_o, .pslverr_o, .done_event_i, .halfway_event_i, .fault_event_i, .irq_o);

  initial forever #10 sys_clk_i = ~sys_clk_i;

  // ==========================================================================
  // Shared tasks
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // An idle cycle follows each transfer, so no strobe is driven twice in one step.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic err);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge sys_clk_i);
    penable_i <= 1'b1;
    @(posedge sys_clk_i);
    while (pready_o !== 1'b1) @(posedge sys_clk_i);
    rd = prdata_o;
    check("slave error", {31'h0, pslverr_o}, {31'h0, err});
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask : apb

  task automatic ev(input logic [7:0] d, input logic [7:0] h, input logic [7:0] f);
    done_event_i <= d;
    halfway_event_i <= h;
    fault_event_i <= f;
    @(posedge sys_clk_i);
    {done_event_i, halfway_event_i, fault_event_i} <= 24'h00_0000;
  endtask : ev

  task automatic rs(input logic [31:0] exp);
    apb(1'b0, 12'h000, 32'h0000_0000, 1'b0);
    check("status", rd, exp);
  endtask : rs

  // ==========================================================================
  // Scenarios
  task automatic t_reset();
    rs(32'h0000_0000);
    apb(1'b0, 12'h004, 32'h0000_0000, 1'b1);
    check("clear read", rd, 32'h0000_0000);
    apb(1'b1, 12'h000, 32'hFFFF_FFFF, 1'b1);
    apb(1'b0, 12'h010, 32'h0000_0000, 1'b1);
  endtask : t_reset

  task automatic t_ch7();
    ev(8'h80, 8'h00, 8'h00);
    rs(32'h3000_0000);
    ev(8'h00, 8'h80, 8'h00);
    rs(32'h7000_0000);
    ev(8'h00, 8'h00, 8'h80);
    rs(32'hF000_0000);
    apb(1'b1, 12'h004, 32'h0000_0000, 1'b0);
    rs(32'hF000_0000);
    apb(1'b1, 12'h004, 32'h2000_0000, 1'b0);
    rs(32'hD000_0000);
    apb(1'b1, 12'h004, 32'h4000_0000, 1'b0);
    rs(32'h9000_0000);
    apb(1'b1, 12'h004, 32'h8000_0000, 1'b0);
    rs(32'h1000_0000);
    apb(1'b1, 12'h004, 32'h1000_0000, 1'b0);
    rs(32'h0000_0000);
  endtask : t_ch7

  task automatic t_layout();
    ev(8'hFF, 8'hFF, 8'hFF);
    rs(32'hFFFF_FFFF);
    apb(1'b1, 12'h004, 32'h0000_0021, 1'b0);
    rs(32'hFFFF_FFD0);
    apb(1'b1, 12'h004, 32'h1111_1110, 1'b0);
    rs(32'h0000_0000);
  endtask : t_layout

  // The event lands on the very edge that takes the clear write.
  task automatic t_race();
    done_event_i <= 8'h08;
    fork
      apb(1'b1, 12'h004, 32'h0000_2000, 1'b0);
      begin
        @(posedge sys_clk_i);
        done_event_i <= 8'h00;
      end
    join
    rs(32'h0000_3000);
  endtask : t_race

  task automatic t_irq();
    check("irq masked", {31'h0, irq_o}, 32'h0);
    apb(1'b1, 12'h00C, 32'h0000_1000, 1'b0);
    check("irq", {31'h0, irq_o}, 32'h1);
    apb(1'b1, 12'h008, 32'h0000_3000, 1'b0);
    check("irq cleared", {31'h0, irq_o}, 32'h0);
  endtask : t_irq

  // A low clock enable must drop an event; a mid-run reset then clears every flag.
  task automatic t_hold();
    ce_i <= 1'b0;
    ev(8'h80, 8'h80, 8'h80);
    ce_i <= 1'b1;
    rs(32'h0000_3000);
    rst_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    @(posedge sys_clk_i);
    rs(32'h0000_0000);
  endtask : t_hold

  // ==========================================================================
  // Run control
  task automatic finish_test();
    if (n_errors == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test

  initial
  begin
    repeat (2) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    @(posedge sys_clk_i);
    t_reset();
    t_ch7();
    t_layout();
    t_race();
    t_irq();
    t_hold();
    finish_test();
  end

  initial
  begin
    #20000;
    n_errors++;
    finish_test();
  end
endmodule : dfs_top_tb
